/* File: dv/ppp_host_model.sv */
`timescale 1ns/1ps
module ppp_host_model (
   input  wire logic       clk_i,
   output logic            strobe_n_o = 1'b1,
   output logic            line_feed_n_o = 1'b1,
   output logic            init_n_o = 1'b1,
   output logic            select_request_n_o = 1'b1,
   output logic [7:0]      data_o = 8'h00
);
   // Data stays valid only two edges past the strobe edge, then turns to garbage.
   task automatic send_byte(input logic [7:0] d);
      @(posedge clk_i);
      data_o <= d;
      @(posedge clk_i);
      strobe_n_o <= 1'b0;
      repeat (2) @(posedge clk_i);
      data_o <= ~d;
      repeat (2) @(posedge clk_i);
      strobe_n_o <= 1'b1;
   endtask
   task automatic set_lines(input logic lf_n, input logic init_n, input logic sel_n);
      @(posedge clk_i);
      line_feed_n_o <= lf_n;
      init_n_o <= init_n;
      select_request_n_o <= sel_n;
   endtask
endmodule

/* File: dv/ppp_top_tb.sv */
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module ppp_top_tb;
   logic        mclk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic        ctl_strobe_i = 1'b1, ctl_line_feed_i = 1'b1, ctl_init_i = 1'b0, ctl_select_in_i = 1'b0;
   logic        ctl_data_ready_i = 1'b0, err;
   logic        pready_o, pslverr_o, ctl_ack_o, ctl_busy_o, ctl_paper_out_o, ctl_select_o, ctl_fault_o;
   logic        host_strobe_n_i, host_line_feed_n_i, host_init_n_i, host_select_request_n_i;
   logic [7:0]  host_data_i;
   logic        peer_acknowledge_n_o, busy_o, paper_out_o, select_status_n_o, fault_flag_n_o, irq_o;
   int          num_errors = 0, n_compared = 0;
   always #5 mclk_i = ~mclk_i;
   ppp_top i_dut (.mclk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .ctl_strobe_i, .ctl_line_feed_i, .ctl_init_i, .ctl_select_in_i,
      .ctl_data_ready_i, .ctl_ack_o, .ctl_busy_o, .ctl_paper_out_o, .ctl_select_o, .ctl_fault_o,
      .host_strobe_n_i, .host_line_feed_n_i, .host_init_n_i, .host_select_request_n_i, .host_data_i,
      .peer_acknowledge_n_o, .busy_o, .paper_out_o, .select_status_n_o, .fault_flag_n_o, .irq_o);
   ppp_host_model i_host (.clk_i(mclk_i), .strobe_n_o(host_strobe_n_i), .line_feed_n_o(host_line_feed_n_i),
      .init_n_o(host_init_n_i), .select_request_n_o(host_select_request_n_i), .data_o(host_data_i));
   task automatic end_of_test();
      if (num_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Entered just after a rising edge; leaves one idle edge so no signal is driven twice in a step.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      rd = prdata_o;
      err = pslverr_o;
      if (n >= 50) num_errors++;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   initial begin
      pause(16);
      resetn_i <= 1'b1;
      @(posedge mclk_i);
      apb(1'b0, `PPP_OFF_CONFIG, 32'h0);
      chk(rd, 32'h3);
      chk(fault_flag_n_o, 32'h0);
      apb(1'b1, `PPP_OFF_MASK, 32'h1);
      i_host.send_byte(8'ha5);
      chk(busy_o, 32'h1);
      pause(20);
      chk(busy_o, 32'h1);
      apb(1'b0, `PPP_OFF_DATA, 32'h0);
      chk(rd, 32'ha5);
      ctl_strobe_i <= 1'b0;
      pause(3);
      chk({peer_acknowledge_n_o, busy_o}, 32'h0);
      ctl_strobe_i <= 1'b1;
      pause(3);
      chk(peer_acknowledge_n_o, 32'h1);
      ctl_init_i <= 1'b1;
      ctl_select_in_i <= 1'b1;
      i_host.set_lines(1'b0, 1'b0, 1'b0);
      pause(3);
      chk({paper_out_o, select_status_n_o, ctl_busy_o, ctl_paper_out_o, ctl_select_o, ctl_ack_o, ctl_fault_o},
          32'h7b);
      i_host.set_lines(1'b1, 1'b1, 1'b1);
      ctl_data_ready_i <= 1'b1;
      @(posedge mclk_i);
      ctl_data_ready_i <= 1'b0;
      pause(12);
      chk(irq_o, 32'h1);
      apb(1'b1, `PPP_OFF_CLEAR, 32'h0);
      pause(2);
      chk(irq_o, 32'h1);
      apb(1'b1, `PPP_OFF_CLEAR, 32'h1);
      pause(2);
      chk(irq_o, 32'h0);
      apb(1'b1, `PPP_OFF_CONFIG, 32'h6);
      pause(2);
      chk(fault_flag_n_o, 32'h1);
      ctl_line_feed_i <= 1'b0;
      pause(3);
      chk(busy_o, 32'h1);
      ctl_line_feed_i <= 1'b1;
      i_host.send_byte(8'h3c);
      pause(3);
      chk(busy_o, 32'h0);
      apb(1'b0, `PPP_OFF_DATA, 32'h0);
      chk(rd, 32'h3c);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      end_of_test();
   end
   // The whole sequence needs well under a thousand cycles.
   initial begin
      #100000;
      num_errors++;
      end_of_test();
   end
endmodule

/* File: hw/ppp_cfg.svh */
`ifndef PPP_CFG_SVH
`define PPP_CFG_SVH
// Register byte offsets on the APB slave.
`define PPP_OFF_DATA      12'h000
`define PPP_OFF_CLEAR     12'h004
`define PPP_OFF_CONFIG    12'h008
`define PPP_OFF_STATUS    12'h00c
`define PPP_OFF_MASK      12'h010
`define PPP_OFF_PINS      12'h014
// Config register fields.
`define PPP_CFG_AUTOBUSY  0
`define PPP_CFG_PERIPH    1
`define PPP_CFG_SPARE     2
`define PPP_CFG_RESET     3'h3
// Status, mask and clear share one layout.
`define PPP_IRQ_READY     0
`define PPP_IRQ_STROBE    1
`define PPP_IRQ_W         2
// Busy must rise within this many nanoseconds of the strobe.
`define PPP_BUSY_MAX_NS   1000
`define PPP_CLK_NS        10
`define PPP_BUSY_MAX_CYC  (`PPP_BUSY_MAX_NS / `PPP_CLK_NS)
`endif

/* File: hw/ppp_pkg.sv */
package ppp_pkg;
   typedef logic [7:0] ppp_byte_t;
endpackage

/* File: hw/ppp_top.sv */
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "ppp_cfg.svh"
module ppp_top (
   input  wire logic        mclk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        ctl_strobe_i,
   input  wire logic        ctl_line_feed_i,
   input  wire logic        ctl_init_i,
   input  wire logic        ctl_select_in_i,
   input  wire logic        ctl_data_ready_i,
   output logic             ctl_ack_o,
   output logic             ctl_busy_o,
   output logic             ctl_paper_out_o,
   output logic             ctl_select_o,
   output logic             ctl_fault_o,
   input  wire logic        host_strobe_n_i,
   input  wire logic        host_line_feed_n_i,
   input  wire logic        host_init_n_i,
   input  wire logic        host_select_request_n_i,
   input  wire logic [7:0]  host_data_i,
   output logic             peer_acknowledge_n_o,
   output logic             busy_o,
   output logic             paper_out_o,
   output logic             select_status_n_o,
   output logic             fault_flag_n_o,
   output logic             irq_o
);
   localparam int BUSY_MAX_CYC = `PPP_BUSY_MAX_CYC;
   initial begin
      if (BUSY_MAX_CYC < 2) $error("busy deadline too short");
      // The deadline checker unrolls a delay range, so the count must stay small.
      if (BUSY_MAX_CYC > 1000) $error("busy deadline too long for the checker");
   end

   typedef struct packed {
      logic [2:0]       cfg;
      logic [2:0]       status;
      logic [2:0]       mask;
      ppp_pkg::ppp_byte_t data;
      logic             strobe_q;
      logic             ack_q;
      logic             busy_latch;
      logic [31:0]      prdata;
      logic             pready;
      logic             pslverr;
      logic             ack_pin;
      logic             busy_pin;
      logic             paper_pin;
      logic             select_pin;
      logic             fault_pin;
      logic             c_ack;
      logic             c_busy;
      logic             c_paper;
      logic             c_select;
      logic             c_fault;
      logic             irq;
   } ppp_state_s;

   ppp_state_s st;
   ppp_state_s next_st;

   logic setup;
   logic wr;
   logic rd;
   logic strobe_fall;
   logic ack_fall;
   logic periph;
   logic autob;
   logic busy_now;
   logic [2:0] events;

   always_comb begin
      next_st     = st;
      setup       = psel_i && !penable_i;
      wr          = setup && pwrite_i;
      rd          = setup && !pwrite_i;
      periph      = st.cfg[`PPP_CFG_PERIPH];
      autob       = st.cfg[`PPP_CFG_AUTOBUSY];
      strobe_fall = st.strobe_q && !host_strobe_n_i;
      ack_fall    = st.ack_q && !ctl_strobe_i;
      next_st.strobe_q = host_strobe_n_i;
      next_st.ack_q    = ctl_strobe_i;
      // The edge register is the only safe way to hold data the host drops early.
      if (strobe_fall) begin
         next_st.data = host_data_i;
      end
      // The strobe edge sets busy at once; only our own acknowledge releases it.
      if (ack_fall) begin
         next_st.busy_latch = 1'b0;
      end
      if (strobe_fall) begin
         next_st.busy_latch = 1'b1;
      end
      busy_now = autob ? (next_st.busy_latch || strobe_fall) : !ctl_line_feed_i;
      events = 3'h0;
      events[`PPP_IRQ_READY]  = ctl_data_ready_i;
      events[`PPP_IRQ_STROBE] = strobe_fall;
      next_st.pready  = setup;
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0;
      if (wr) begin
         case (paddr_i)
            `PPP_OFF_CONFIG: next_st.cfg = pwdata_i[2:0];
            `PPP_OFF_MASK:   next_st.mask = pwdata_i[2:0];
            `PPP_OFF_CLEAR:  next_st.status = st.status & ~pwdata_i[2:0];
            default:         next_st.pslverr = (paddr_i != `PPP_OFF_CLEAR);
         endcase
      end
      if (rd) begin
         case (paddr_i)
            `PPP_OFF_DATA:   next_st.prdata = {24'h0, st.data};
            `PPP_OFF_CONFIG: next_st.prdata = {29'h0, st.cfg};
            `PPP_OFF_STATUS: begin
               next_st.prdata = {29'h0, st.status};
               next_st.status = 3'h0;
            end
            `PPP_OFF_MASK:   next_st.prdata = {29'h0, st.mask};
            `PPP_OFF_PINS:   next_st.prdata = {26'h0, st.busy_pin, st.ack_pin, host_init_n_i,
                                               host_select_request_n_i, host_line_feed_n_i, host_strobe_n_i};
            default:         next_st.pslverr = 1'b1;
         endcase
      end
      // Events win over any clear in the same cycle.
      next_st.status = next_st.status | events;
      next_st.irq = |(next_st.status & next_st.mask);
      // Idle levels are driven when not in peripheral mode.
      next_st.ack_pin    = periph ? ctl_strobe_i    : 1'b1;
      next_st.busy_pin   = periph ? busy_now        : 1'b0;
      next_st.paper_pin  = periph ? ctl_init_i      : 1'b0;
      next_st.select_pin = periph ? ctl_select_in_i : 1'b1;
      next_st.fault_pin  = periph ? st.cfg[`PPP_CFG_SPARE] : 1'b1;
      next_st.c_ack      = host_strobe_n_i;
      next_st.c_busy     = !host_line_feed_n_i;
      next_st.c_paper    = !host_init_n_i;
      next_st.c_select   = host_select_request_n_i;
      next_st.c_fault    = 1'b1;
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         st            <= '0;
         st.cfg        <= `PPP_CFG_RESET;
         st.strobe_q   <= 1'b1;
         st.ack_q      <= 1'b1;
         st.ack_pin    <= 1'b1;
         st.select_pin <= 1'b1;
         st.fault_pin  <= 1'b1;
         st.c_ack      <= 1'b1;
         st.c_select   <= 1'b1;
         st.c_fault    <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign prdata_o             = st.prdata;
   assign pready_o             = st.pready;
   assign pslverr_o            = st.pslverr;
   assign peer_acknowledge_n_o = st.ack_pin;
   assign busy_o               = st.busy_pin;
   assign paper_out_o          = st.paper_pin;
   assign select_status_n_o    = st.select_pin;
   assign fault_flag_n_o       = st.fault_pin;
   assign ctl_ack_o            = st.c_ack;
   assign ctl_busy_o           = st.c_busy;
   assign ctl_paper_out_o      = st.c_paper;
   assign ctl_select_o         = st.c_select;
   assign ctl_fault_o          = st.c_fault;
   assign irq_o                = st.irq;

   sequence s_strobe_edge;
      $fell(host_strobe_n_i);
   endsequence

   sequence s_ack_edge;
      $fell(ctl_strobe_i);
   endsequence

   AST_BUSY_FAST: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      s_strobe_edge and st.cfg[`PPP_CFG_AUTOBUSY] && st.cfg[`PPP_CFG_PERIPH] |=> busy_o)
      else $error("busy not raised after strobe");
   AST_BUSY_HOLD: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st.busy_latch && !ack_fall && st.cfg[`PPP_CFG_AUTOBUSY] |=> st.busy_latch)
      else $error("busy released without acknowledge");
   AST_BUSY_REL: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      s_ack_edge and host_strobe_n_i && st.strobe_q |=> !st.busy_latch)
      else $error("acknowledge did not release busy");
   AST_CAPTURE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      s_strobe_edge |=> st.data == $past(host_data_i))
      else $error("data not captured on strobe edge");
   AST_FOLLOW: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !st.cfg[`PPP_CFG_AUTOBUSY] && st.cfg[`PPP_CFG_PERIPH] && $stable(st.cfg) |=> busy_o == !$past(ctl_line_feed_i))
      else $error("busy does not follow line feed control");
   AST_FAULT: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st.cfg[`PPP_CFG_PERIPH] && $stable(st.cfg) |=> fault_flag_n_o == $past(st.cfg[`PPP_CFG_SPARE]))
      else $error("fault flag not from spare bit");
   AST_ACK_MAP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st.cfg[`PPP_CFG_PERIPH] && $stable(st.cfg) |=> peer_acknowledge_n_o == $past(ctl_strobe_i))
      else $error("acknowledge not cross connected");
   AST_LATCH: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      ctl_data_ready_i |=> st.status[`PPP_IRQ_READY])
      else $error("data ready pulse not latched");
   AST_CLEAR0: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      wr && paddr_i == `PPP_OFF_CLEAR && !pwdata_i[`PPP_IRQ_READY] && st.status[`PPP_IRQ_READY]
      |=> st.status[`PPP_IRQ_READY])
      else $error("zero write cleared the latch");

   sequence s_clear_ready;
      wr && paddr_i == `PPP_OFF_CLEAR && pwdata_i[`PPP_IRQ_READY] && !ctl_data_ready_i;
   endsequence

   sequence s_config_write;
      wr && paddr_i == `PPP_OFF_CONFIG;
   endsequence

   sequence s_data_read;
      rd && paddr_i == `PPP_OFF_DATA;
   endsequence

   sequence s_ro_write;
      wr && (paddr_i == `PPP_OFF_DATA || paddr_i == `PPP_OFF_STATUS || paddr_i == `PPP_OFF_PINS);
   endsequence

   // The fast path answers in one cycle; this guards the hard limit should a stage ever be added.
   AST_BUSY_DEADLINE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      s_strobe_edge and (st.cfg[`PPP_CFG_AUTOBUSY] && st.cfg[`PPP_CFG_PERIPH]) |-> ##[1:BUSY_MAX_CYC] busy_o)
      else $error("busy missed its deadline");

   AST_CLEAR1: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      s_clear_ready |=> !st.status[`PPP_IRQ_READY])
      else $error("one write did not clear the latch");

   AST_STATUS_KEEP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st.status[`PPP_IRQ_READY] && !(wr && paddr_i == `PPP_OFF_CLEAR && pwdata_i[`PPP_IRQ_READY])
      && !(rd && paddr_i == `PPP_OFF_STATUS) |=> st.status[`PPP_IRQ_READY])
      else $error("latched data ready lost without a clear");

   AST_IRQ_LEVEL: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      irq_o == |(st.status & st.mask))
      else $error("interrupt line disagrees with status and mask");

   AST_CFG_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      s_config_write |=> {29'h0, st.cfg} == ($past(pwdata_i) & 32'h0000_0007))
      else $error("config write not taken");

   AST_READ_DATA: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      s_data_read |=> prdata_o == {24'h0, $past(st.data)})
      else $error("captured byte not returned on read");

   AST_RO_WRITE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      s_ro_write |=> pslverr_o)
      else $error("write to read only register not refused");

   AST_PREADY: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      1'b1 |=> pready_o == $past(setup))
      else $error("ready does not follow the setup cycle");

   AST_PAPER_MAP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st.cfg[`PPP_CFG_PERIPH] && $stable(st.cfg) |=> paper_out_o == $past(ctl_init_i))
      else $error("paper out not cross connected");

   AST_SELECT_MAP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      st.cfg[`PPP_CFG_PERIPH] && $stable(st.cfg) |=> select_status_n_o == $past(ctl_select_in_i))
      else $error("select status not cross connected");

   // Outside peripheral mode the connector must look like an idle, deselected printer.
   AST_IDLE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      !st.cfg[`PPP_CFG_PERIPH] && $stable(st.cfg) |=> peer_acknowledge_n_o && select_status_n_o
      && fault_flag_n_o && !busy_o && !paper_out_o)
      else $error("connector not idle outside peripheral mode");

   AST_CTL_ACK: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      1'b1 |=> ctl_ack_o == $past(host_strobe_n_i))
      else $error("controller acknowledge not from host strobe");

   AST_CTL_BUSY: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      1'b1 |=> ctl_busy_o == !$past(host_line_feed_n_i))
      else $error("controller busy not from host line feed");

   AST_CTL_PAPER: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      1'b1 |=> ctl_paper_out_o == !$past(host_init_n_i))
      else $error("controller paper out not from host init");

   AST_CTL_SELECT: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      1'b1 |=> ctl_select_o == $past(host_select_request_n_i))
      else $error("controller select not from host select request");

   AST_CTL_FAULT: assert property (@(posedge mclk_i) disable iff (!resetn_i)
      ctl_fault_o)
      else $error("controller fault input not held inactive");
endmodule
